// [inc/mch_pkg.sv]
package mch_pkg;
  // ---------------------------------------------------------------
  // register offsets (register index on the plain port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_FIFO = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_SUBADDR = 4'h2;
  localparam logic [3:0] ADDR_CMD = 4'h3;
  localparam logic [3:0] ADDR_ISTAT = 4'h4;
  localparam logic [3:0] ADDR_ACTIVE = 4'h5;
  localparam logic [3:0] ADDR_MODE = 4'h6;
  // ---------------------------------------------------------------
  // command bits
  // ---------------------------------------------------------------
  localparam int CMD_FRESET = 0;
  localparam int CMD_SEARCH = 1;
  localparam int CMD_XFER_LO = 2;
  localparam int CMD_XFER_HI = 3;
  localparam logic [1:0] XFER_IDLE = 2'h0;
  localparam logic [1:0] XFER_TX = 2'h1;
  localparam logic [1:0] XFER_TXRX = 2'h2;
  localparam logic [1:0] XFER_CONT = 2'h3;
  // ---------------------------------------------------------------
  // status, interrupt and mode bit positions
  // ---------------------------------------------------------------
  localparam int ST_EMPTY = 0;
  localparam int ST_RW = 1;
  localparam int ST_AE = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_BUSY = 4;
  localparam int IS_ACTIVE = 4;
  localparam int IS_DONE = 5;
  localparam int MODE_INIT = 0;
  localparam int MODE_HS = 1;
  localparam int MODE_SAMELINE = 2;
  localparam int AC_SEARCH = 6;
  // subscriber address: [7:6] count or type, [5:0] slot
  localparam logic [1:0] SUB_BCAST = 2'h1;
  localparam logic [1:0] SUB_TEST = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int FRESET_REFCLK = 2;
  localparam int HS_GAP_FRAMES = 2;
  localparam int BCAST_FRAMES = 3;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam int SAMELINE_OFFSET = 4;
  localparam int SLOT_W = 6;
endpackage

// [rtl/mch_fifo.sv]
`timescale 1ns/100ps
module mch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // control
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  // state
  output logic [WIDTH-1:0] pop_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("depth must be a power of two");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic do_push;
  logic do_pop;
  assign do_push = push && (count != (AW+1)'(DEPTH));
  assign do_pop = pop && (count != '0);
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_q] <= push_data;
    end
  end
  // read data registered; shows head after every pointer move except a push and pop together on a one-entry fifo
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pop_data <= '0;
    end else begin
      pop_data <= (do_push && count == '0) ? push_data :
        mem[do_pop ? rd_q + 1'b1 : rd_q];
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      count <= '0;
    end else if (clear) begin
      wr_q <= '0;
      rd_q <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// [rtl/mch_handler.sv]
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
// What this block does
// - host fills fifo, sets address, writes transmit; bytes go out in turn
// - without handshake, exactly one byte leaves per frame
// - with handshake, each byte acked first except in broadcast; at most one byte per two frames
// - receiver handshake idle two frames during transmit aborts, flags, irq
// - all bytes sent and acked raises the fifo interrupt
// - with handshake, continuous transmit keeps handshake active on empty fifo and irqs
// - transmit plus receive sends then receives; empty fifo gives receive only
// - handshaked receive self-acks, stores 16, ends after two idle frames
// - fifo reset cancels a receive at any time
// - seventeenth byte irqs, stays unacked; reissued command resumes
// - no handshake: receive 1, 2, 8 or 16 frames, then irq
// - same-line mode receives four slots after the transmit slot
// - broadcast on marked slots, one byte per two frames with handshake, acks ignored
// - test mode loops fifo back, same status as transmit
// - search scans upstream slots for active handshake, stores, irqs
// - search ends only on a find or init-mode bit cleared
// - fifo reset clears fifo and transfer but not search, in two clocks
// - reading interrupt status clears both interrupt flags
module mch_handler #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // frame timing from the serial interface
  input wire logic frame_start,
  input wire logic slot_valid,
  input wire logic [5:0] slot_num,
  input wire logic slot_marked,
  // monitor slot data
  input wire logic [7:0] up_data,
  input wire logic up_tx_hs_n,
  input wire logic up_rx_hs_n,
  output logic [7:0] down_data,
  output logic down_tx_hs_n,
  output logic down_rx_hs_n,
  output logic down_en,
  // interrupt flags
  output logic fifo_done_irq,
  output logic channel_active_irq
);
  initial begin
    if (DEPTH != mch_pkg::FIFO_DEPTH) begin
      $error("monitor fifo depth is fixed at sixteen");
    end
  end
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SEND = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_RECV = 6'b001000,
    ST_HOLD = 6'b010000,
    ST_RST = 6'b100000
  } mch_state_t;
  mch_state_t state_q;
  logic [7:0] subscriber_address_reg_q, operation_mode_reg_q;
  logic [7:0] hold_byte_q, fhead, fpush_data;
  logic [5:0] active_chan_q, rx_target;
  logic [4:0] rxcnt_q, fcount, rx_limit;
  logic [1:0] xfer_q, gap_q, idle_q, rst_q;
  logic abort_q, searching_q, hold_valid_q, done_set, act_set;
  logic fpush, fpop, fclear, hs_on, cmd_wr, my_slot, rx_slot, ist_rd;
  logic test_mode, bcast;
  // ---------------------------------------------------------------
  // fifo
  // ---------------------------------------------------------------
  mch_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(fclear),
    .push(fpush),
    .push_data(fpush_data),
    .pop(fpop),
    .pop_data(fhead),
    .count(fcount)
  );
  assign hs_on = operation_mode_reg_q[mch_pkg::MODE_HS];
  assign cmd_wr = reg_wr && reg_addr == mch_pkg::ADDR_CMD;
  assign ist_rd = reg_rd && reg_addr == mch_pkg::ADDR_ISTAT;
  assign test_mode = subscriber_address_reg_q[7:6] == mch_pkg::SUB_TEST &&
    reg_wdata[mch_pkg::CMD_XFER_HI:mch_pkg::CMD_XFER_LO] == mch_pkg::XFER_TX;
  assign bcast = subscriber_address_reg_q[7:6] == mch_pkg::SUB_BCAST &&
    xfer_q == mch_pkg::XFER_TX;
  assign my_slot = slot_valid &&
    (bcast ? slot_marked :
     slot_num == subscriber_address_reg_q[5:0]);
  // same-line reply sits four slots later, upstream
  assign rx_target = operation_mode_reg_q[mch_pkg::MODE_SAMELINE] ?
    subscriber_address_reg_q[5:0] +
    6'(mch_pkg::SAMELINE_OFFSET) :
    subscriber_address_reg_q[5:0];
  assign rx_slot = slot_valid && slot_num == rx_target;
  // fifo reset lasts two clocks, then the fifo is usable
  assign fclear = state_q == ST_RST;
  // ---------------------------------------------------------------
  // received byte count limit without handshake
  // ---------------------------------------------------------------
  always_comb begin
    unique case (subscriber_address_reg_q[7:6])
      2'h0: rx_limit = 5'h01;
      2'h1: rx_limit = 5'h02;
      2'h2: rx_limit = 5'h08;
      2'h3: rx_limit = 5'h10;
    endcase
  end
  // ---------------------------------------------------------------
  // fifo traffic: host writes, transmit pops, receive pushes
  // ---------------------------------------------------------------
  always_comb begin
    fpush = 1'b0;
    fpop = 1'b0;
    fpush_data = reg_wdata;
    if (reg_wr && reg_addr == mch_pkg::ADDR_FIFO &&
        (state_q == ST_IDLE || state_q == ST_HOLD)) begin
      fpush = 1'b1;
    end
    if (reg_rd && reg_addr == mch_pkg::ADDR_FIFO) begin
      fpop = 1'b1;
    end
    if (state_q == ST_SEND && my_slot && fcount != '0 && gap_q == '0) begin
      fpop = 1'b1;
    end
    // captured byte lands a cycle after its slot, the last one included
    if (hold_valid_q && fcount != mch_pkg::FIFO_FULL) begin
      fpush = 1'b1;
      fpush_data = hold_byte_q;
    end
  end
  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      xfer_q <= mch_pkg::XFER_IDLE;
      gap_q <= '0;
      idle_q <= '0;
      rxcnt_q <= '0;
      rst_q <= '0;
      abort_q <= 1'b0;
      hold_valid_q <= 1'b0;
      hold_byte_q <= '0;
      down_data <= '0;
      down_tx_hs_n <= 1'b1;
      down_rx_hs_n <= 1'b1;
      down_en <= 1'b0;
      done_set <= 1'b0;
    end else begin
      done_set <= 1'b0;
      down_en <= 1'b0;
      hold_valid_q <= 1'b0;
      if (frame_start && gap_q != '0) begin
        gap_q <= gap_q - 2'h1;
      end
      if (cmd_wr && reg_wdata[mch_pkg::CMD_FRESET]) begin
        // cancels any transfer, receive included
        state_q <= ST_RST;
        rst_q <= 2'(mch_pkg::FRESET_REFCLK - 1);
        abort_q <= 1'b0;
        down_tx_hs_n <= 1'b1;
        down_rx_hs_n <= 1'b1;
      end else begin
        unique case (state_q)
          ST_RST: begin
            if (rst_q == '0) begin
              state_q <= ST_IDLE;
            end else begin
              rst_q <= rst_q - 2'd1;
            end
          end
          ST_IDLE, ST_HOLD: begin
            if (cmd_wr && reg_wdata[mch_pkg::CMD_XFER_HI:
                mch_pkg::CMD_XFER_LO] != mch_pkg::XFER_IDLE) begin
              xfer_q <= reg_wdata[mch_pkg::CMD_XFER_HI:
                mch_pkg::CMD_XFER_LO];
              gap_q <= '0;
              idle_q <= '0;
              rxcnt_q <= '0;
              if (test_mode) begin
                // nothing goes out; fifo is left for read back
                state_q <= ST_IDLE;
                done_set <= 1'b1;
              end else begin
                state_q <= ST_SEND;
              end
            end
          end
          ST_SEND: begin
            if (my_slot) begin
              if (fcount != '0 && gap_q == '0) begin
                down_data <= fhead;
                down_en <= 1'b1;
                down_tx_hs_n <= 1'b0;
                idle_q <= '0;
                if (bcast && hs_on) begin
                  gap_q <= 2'(mch_pkg::BCAST_FRAMES - 1);
                end else if (hs_on) begin
                  state_q <= ST_WAIT;
                  gap_q <= 2'(mch_pkg::HS_GAP_FRAMES - 1);
                end
              end else if (fcount == '0) begin
                if (xfer_q == mch_pkg::XFER_CONT && hs_on) begin
                  state_q <= ST_HOLD;
                  done_set <= 1'b1;
                end else if (xfer_q == mch_pkg::XFER_TXRX) begin
                  down_tx_hs_n <= 1'b1;
                  state_q <= ST_RECV;
                end else begin
                  down_tx_hs_n <= 1'b1;
                  state_q <= ST_IDLE;
                  done_set <= 1'b1;
                end
              end
            end
          end
          ST_WAIT: begin
            if (rx_slot) begin
              if (!up_rx_hs_n) begin
                idle_q <= '0;
                if (gap_q == '0) begin
                  state_q <= ST_SEND;
                end
              end else if (idle_q == 2'(mch_pkg::HS_GAP_FRAMES - 1)) begin
                state_q <= ST_IDLE;
                abort_q <= 1'b1;
                done_set <= 1'b1;
                down_tx_hs_n <= 1'b1;
              end else begin
                idle_q <= idle_q + 2'd1;
              end
            end
          end
          ST_RECV: begin
            if (rx_slot) begin
              if (hs_on) begin
                if (!up_tx_hs_n) begin
                  idle_q <= '0;
                  hold_byte_q <= up_data;
                  if (fcount == mch_pkg::FIFO_FULL) begin
                    // seventeenth byte waits unacked
                    down_rx_hs_n <= 1'b1;
                    done_set <= 1'b1;
                    state_q <= ST_HOLD;
                  end else begin
                    down_rx_hs_n <= 1'b0;
                    hold_valid_q <= 1'b1;
                  end
                end else if (idle_q == 2'(mch_pkg::HS_GAP_FRAMES - 1)) begin
                  state_q <= ST_IDLE;
                  done_set <= 1'b1;
                  down_rx_hs_n <= 1'b1;
                end else begin
                  idle_q <= idle_q + 2'd1;
                end
              end else begin
                hold_byte_q <= up_data;
                hold_valid_q <= 1'b1;
                rxcnt_q <= rxcnt_q + 5'd1;
                if (rxcnt_q + 5'd1 == rx_limit) begin
                  state_q <= ST_IDLE;
                  done_set <= 1'b1;
                end
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // active channel search, untouched by fifo reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      searching_q <= 1'b0;
      active_chan_q <= '0;
      act_set <= 1'b0;
    end else begin
      act_set <= 1'b0;
      if (!operation_mode_reg_q[mch_pkg::MODE_INIT]) begin
        searching_q <= 1'b0;
      end else if (searching_q && slot_valid && !up_tx_hs_n) begin
        searching_q <= 1'b0;
        active_chan_q <= slot_num;
        act_set <= 1'b1;
      end else if (cmd_wr && reg_wdata[mch_pkg::CMD_SEARCH]) begin
        searching_q <= 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // registers and interrupt flags
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      subscriber_address_reg_q <= '0;
      operation_mode_reg_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == mch_pkg::ADDR_SUBADDR) begin
        subscriber_address_reg_q <= reg_wdata;
      end
      if (reg_addr == mch_pkg::ADDR_MODE) begin
        operation_mode_reg_q <= reg_wdata;
      end
    end
  end
  // a set in the clearing cycle wins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fifo_done_irq <= 1'b0;
      channel_active_irq <= 1'b0;
    end else begin
      fifo_done_irq <= done_set || (fifo_done_irq && !ist_rd);
      channel_active_irq <= act_set || (channel_active_irq && !ist_rd);
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          mch_pkg::ADDR_FIFO: reg_rdata <= fhead;
          mch_pkg::ADDR_STATUS: begin
            reg_rdata[mch_pkg::ST_EMPTY] <= fcount == '0;
            reg_rdata[mch_pkg::ST_RW] <= state_q == ST_IDLE &&
              xfer_q != mch_pkg::XFER_TX;
            reg_rdata[mch_pkg::ST_AE] <= state_q == ST_IDLE ||
              state_q == ST_HOLD;
            reg_rdata[mch_pkg::ST_ABORT] <= abort_q;
            reg_rdata[mch_pkg::ST_BUSY] <= state_q != ST_IDLE &&
              state_q != ST_RST;
          end
          mch_pkg::ADDR_SUBADDR: reg_rdata <= subscriber_address_reg_q;
          mch_pkg::ADDR_ISTAT: begin
            reg_rdata[mch_pkg::IS_DONE] <= fifo_done_irq;
            reg_rdata[mch_pkg::IS_ACTIVE] <= channel_active_irq;
          end
          mch_pkg::ADDR_ACTIVE:
            reg_rdata <= {1'b0, searching_q, active_chan_q};
          mch_pkg::ADDR_MODE: reg_rdata <= operation_mode_reg_q;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule

// [tb/mch_handler_props.sv]
`timescale 1ns/100ps
module mch_handler_props #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // frame timing
  input wire logic frame_start,
  input wire logic slot_valid,
  input wire logic [5:0] slot_num,
  input wire logic slot_marked,
  // monitor slots
  input wire logic [7:0] up_data,
  input wire logic up_tx_hs_n,
  input wire logic up_rx_hs_n,
  input wire logic [7:0] down_data,
  input wire logic down_tx_hs_n,
  input wire logic down_rx_hs_n,
  input wire logic down_en,
  // interrupts
  input wire logic fifo_done_irq,
  input wire logic channel_active_irq
);
  logic [7:0] mode_q;
  logic [7:0] sub_q;
  logic [1:0] gap_q;
  logic [2:0] age_q;
  logic ist_rd;
  logic norm;
  assign ist_rd = reg_rd && reg_addr == mch_pkg::ADDR_ISTAT;
  // broadcast pops a new byte at marked slots, every second frame with handshake, so slot and spacing follow the marks
  assign norm = sub_q[7:6] != mch_pkg::SUB_BCAST;
  // ----
  // shadows and counters
  // ----
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_q <= 8'h00;
      sub_q <= 8'h00;
    end else if (reg_wr && reg_addr == mch_pkg::ADDR_MODE) begin
      mode_q <= reg_wdata;
    end else if (reg_wr && reg_addr == mch_pkg::ADDR_SUBADDR) begin
      sub_q <= reg_wdata;
    end
  end
  // frames since last byte; a new command restarts it saturated
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gap_q <= 2'h3;
    end else if (down_en) begin
      gap_q <= 2'h0;
    end else if (reg_wr && reg_addr == mch_pkg::ADDR_CMD) begin
      gap_q <= 2'h3;
    end else if (frame_start && gap_q != 2'h3) begin
      gap_q <= gap_q + 2'h1;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      age_q <= 3'h7;
    end else if (slot_valid && !up_tx_hs_n) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero");
  property p_istat;
    ist_rd |=> reg_rdata == {2'h0, $past(fifo_done_irq),
      $past(channel_active_irq), 4'h0};
  endproperty
  a_istat: assert property (p_istat)
    else $error("interrupt status wrong");
  property p_done_sticky;
    fifo_done_irq && !ist_rd |=> fifo_done_irq;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("done flag lost");
  property p_act_sticky;
    channel_active_irq && !ist_rd |=> channel_active_irq;
  endproperty
  a_act_sticky: assert property (p_act_sticky)
    else $error("active flag lost");
  property p_freset;
    reg_wr && reg_addr == mch_pkg::ADDR_CMD && reg_wdata == 8'h01
      |-> ##2 down_tx_hs_n && down_rx_hs_n;
  endproperty
  a_freset: assert property (p_freset)
    else $error("transfer not cleared");
  property p_nohs_rate;
    down_en && norm && !mode_q[mch_pkg::MODE_HS]
      |-> gap_q == 2'h1 || gap_q == 2'h3;
  endproperty
  a_nohs_rate: assert property (p_nohs_rate)
    else $error("byte rate not one per frame");
  property p_hs_rate;
    down_en && norm && mode_q[mch_pkg::MODE_HS] |-> gap_q >= 2'h2;
  endproperty
  a_hs_rate: assert property (p_hs_rate)
    else $error("handshake byte too early");
  property p_on_slot;
    down_en && norm |-> $past(slot_valid) && $past(slot_num) == sub_q[5:0];
  endproperty
  a_on_slot: assert property (p_on_slot)
    else $error("byte on wrong slot");
  property p_act_cause;
    $rose(channel_active_irq) |-> age_q <= 3'h3;
  endproperty
  a_act_cause: assert property (p_act_cause)
    else $error("active flag without active slot");
endmodule
bind mch_handler mch_handler_props #(.DEPTH(DEPTH)) mch_handler_props_i (.*);

// [tb/mch_sub_model.sv]
`timescale 1ns/100ps
module mch_sub_model #(
  parameter logic [5:0] MY_SLOT = 6'h05
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // scenario control
  input wire logic ack_en,
  input wire logic act_en,
  input wire logic [5:0] act_slot,
  // frame and upstream
  output logic frame_start,
  output logic slot_valid,
  output logic [5:0] slot_num,
  output logic slot_marked,
  output logic [7:0] up_data,
  output logic up_tx_hs_n,
  output logic up_rx_hs_n,
  // downstream and log
  input wire logic [7:0] down_data,
  input wire logic down_en,
  output logic [7:0] sent_cnt
);
  logic [5:0] cyc_q;
  logic [7:0] frame_q;
  logic ack_q;
  logic [7:0] byte_q [0:31];
  logic [7:0] fr_q [0:31];
  logic sv;
  logic [5:0] sn;
  assign sv = cyc_q[1:0] == 2'h3 && cyc_q < 6'h20;
  assign sn = {3'h0, cyc_q[4:2]};
  // ----
  // 40-clock frame, eight slots
  // ----
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cyc_q <= 6'h00;
      frame_q <= 8'h00;
      ack_q <= 1'b0;
      sent_cnt <= 8'h00;
      frame_start <= 1'b0;
      slot_valid <= 1'b0;
      slot_num <= 6'h00;
      slot_marked <= 1'b0;
      up_data <= 8'h00;
      up_tx_hs_n <= 1'b1;
      up_rx_hs_n <= 1'b1;
    end else begin
      cyc_q <= (cyc_q == 6'h27) ? 6'h00 : cyc_q + 6'h01;
      frame_start <= cyc_q == 6'h27;
      if (cyc_q == 6'h27) begin
        frame_q <= frame_q + 8'h01;
      end
      slot_valid <= sv;
      slot_num <= sn;
      slot_marked <= sv && sn == MY_SLOT;
      // outside slots the line toggles so stale data never looks valid
      up_data <= sv ? {frame_q[3:0], 1'b0, cyc_q[4:2]} : ~up_data;
      up_tx_hs_n <= !(sv && act_en && sn == act_slot);
      // ack one frame after the byte, on the same slot
      up_rx_hs_n <= !(sv && sn == MY_SLOT && ack_en && ack_q);
      if (down_en) begin
        ack_q <= 1'b1;
      end else if (sv && sn == MY_SLOT) begin
        ack_q <= 1'b0;
      end
      if (down_en && sent_cnt < 8'h20) begin
        byte_q[sent_cnt[4:0]] <= down_data;
        fr_q[sent_cnt[4:0]] <= frame_q;
        sent_cnt <= sent_cnt + 8'h01;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ack_en = 1'b0;
  logic act_en = 1'b0;
  logic [5:0] act_slot = 6'h00;
  logic [7:0] reg_rdata, up_data, down_data, sent_cnt, d, base;
  logic frame_start, slot_valid, slot_marked, up_tx_hs_n, up_rx_hs_n;
  logic down_tx_hs_n, down_rx_hs_n, down_en, fifo_done_irq;
  logic channel_active_irq;
  logic [5:0] slot_num;
  int error_cnt = 0;
  int checked = 0;
  always #2 ref_clk = ~ref_clk;
  mch_handler mch_handler_i (.*);
  mch_sub_model mch_sub_model_i (.*);
  // ----
  // bus tasks and checks
  // ----
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_irq(input bit act, input logic [7:0] ist);
    int n;
    logic [7:0] v;
    n = 0;
    while ((act ? channel_active_irq : fifo_done_irq) !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 4000) begin
        error_cnt++;
        $display("ERROR irq expected 1 seen 0");
        give_verdict();
      end
    end
    rd(mch_pkg::ADDR_ISTAT, v);
    chk("istat", v, ist);
    rd(mch_pkg::ADDR_ISTAT, v);
    chk("istat_clear", v, 8'h00);
  endtask
  // the fifo stays blocked two clocks after a reset, so let them pass
  task automatic freset();
    wr(mch_pkg::ADDR_CMD, 8'h01);
    @(posedge ref_clk);
    #1 base = sent_cnt;
  endtask
  // clears first, as the host must before any transfer
  task automatic send(input logic [7:0] sub, cmd, input int n);
    freset();
    for (int i = 0; i < n; i++) begin
      wr(mch_pkg::ADDR_FIFO, 8'hA1 + 8'(i) * 8'h11);
    end
    wr(mch_pkg::ADDR_SUBADDR, sub);
    wr(mch_pkg::ADDR_CMD, cmd);
  endtask
  task automatic chk_sent(input int n, input bit hs);
    logic [7:0] g;
    chk("sent", sent_cnt - base, 8'(n));
    for (int i = 0; i < n; i++) begin
      chk("byte", mch_sub_model_i.byte_q[base[4:0] + 5'(i)],
        8'hA1 + 8'(i) * 8'h11);
      if (i > 0) begin
        g = mch_sub_model_i.fr_q[base[4:0] + 5'(i)] -
          mch_sub_model_i.fr_q[base[4:0] + 5'(i) - 5'h1];
        chk("gap", {7'h00, hs ? g >= 8'h02 : g == 8'h01}, 8'h01);
      end
    end
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'hF, d);
    chk("unmapped", d, 8'h00);
    wr(mch_pkg::ADDR_MODE, 8'h01);
    send(8'h05, 8'h04, 3);
    wait_irq(1'b0, 8'h20);
    chk_sent(3, 1'b0);
    ack_en <= 1'b1;
    wr(mch_pkg::ADDR_MODE, 8'h03);
    send(8'h05, 8'h04, 3);
    wait_irq(1'b0, 8'h20);
    chk_sent(3, 1'b1);
    send(8'h05, 8'h0C, 1);
    wait_irq(1'b0, 8'h20);
    chk("hold_hs", {7'h00, down_tx_hs_n}, 8'h00);
    wr(mch_pkg::ADDR_FIFO, 8'hB2);
    wr(mch_pkg::ADDR_CMD, 8'h04);
    wait_irq(1'b0, 8'h20);
    chk_sent(2, 1'b1);
    ack_en <= 1'b0;
    send(8'h05, 8'h04, 2);
    wait_irq(1'b0, 8'h20);
    chk("abort_sent", sent_cnt - base, 8'h01);
    rd(mch_pkg::ADDR_STATUS, d);
    chk("aborted", {7'h00, d[mch_pkg::ST_ABORT]}, 8'h01);
    freset();
    rd(mch_pkg::ADDR_STATUS, d);
    chk("status", d, 8'h05);
    send(8'h85, 8'h04, 2);
    wait_irq(1'b0, 8'h20);
    chk_sent(0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      rd(mch_pkg::ADDR_FIFO, d);
      chk("loopback", d, 8'hA1 + 8'(i) * 8'h11);
    end
    wr(mch_pkg::ADDR_MODE, 8'h01);
    send(8'h45, 8'h08, 1);
    wait_irq(1'b0, 8'h20);
    for (int i = 0; i < 2; i++) begin
      rd(mch_pkg::ADDR_STATUS, d);
      chk("not_empty", {7'h00, d[mch_pkg::ST_EMPTY]}, 8'h00);
      rd(mch_pkg::ADDR_FIFO, d);
      chk("rx_slot", {4'h0, d[3:0]}, 8'h05);
    end
    rd(mch_pkg::ADDR_STATUS, d);
    chk("empty", {7'h00, d[mch_pkg::ST_EMPTY]}, 8'h01);
    wr(mch_pkg::ADDR_MODE, 8'h03);
    act_slot <= 6'h03;
    act_en <= 1'b1;
    wr(mch_pkg::ADDR_CMD, 8'h02);
    wait_irq(1'b1, 8'h10);
    rd(mch_pkg::ADDR_ACTIVE, d);
    chk("active", d, 8'h03);
    act_en <= 1'b0;
    wr(mch_pkg::ADDR_CMD, 8'h02);
    wr(mch_pkg::ADDR_CMD, 8'h01);
    rd(mch_pkg::ADDR_ACTIVE, d);
    chk("searching", {7'h00, d[mch_pkg::AC_SEARCH]}, 8'h01);
    wr(mch_pkg::ADDR_MODE, 8'h02);
    rd(mch_pkg::ADDR_ACTIVE, d);
    chk("stopped", {7'h00, d[mch_pkg::AC_SEARCH]}, 8'h00);
    give_verdict();
  end
endmodule
